/* File: inc/cpc_pkg.sv */
// Contract
// - controller approves repeater list after checks; device clears it.
// - receiver key approval set by one; clears on key ready; zero ignored.
// - writing one to bit 3 sends plain video, keeps authentication.
// - encryption enabled: encrypted if authenticated, else blue screen.
// - encryption enable clear means video goes out without encryption.
// - always-encrypt policy makes encryption enable read-only, reading one.
// - writing one to bit 1 disables authentication; bit self-clears.
// - writing one to bit 0 enables or restarts auth; zero ignored.
// - reading bit 0 returns the present authentication enable state.
// - status bit 7 flags link channel error, cleared by status read.
// - status bit 6 mirrors receiver interrupt level, active low.
// - status bit 5 shows downstream receiver lock.
// - status register reads 0x00 after reset.
// - writing one to bit 7 resets the transmitter, disables auth.
// - policy 00 when-authenticated, 01 register, 10 always, 11 in-band.
// - key ready set on key read, cleared on approval or failure.
package cpc_pkg;

	// ********************************************************
	// register map
	// ********************************************************
	localparam logic [7:0] CPC_CTRL_ADDR   = 8'hC3;
	localparam logic [7:0] CPC_STATUS_ADDR = 8'hC4;
	localparam logic [7:0] CPC_STATUS_RST  = 8'h00;
	localparam logic [7:0] CPC_RDATA_RST   = 8'h00;

	// control bit positions
	localparam int CTL_PROTECT_RESET  = 7;
	localparam int CTL_RESERVED       = 6;
	localparam int CTL_LIST_APPROVED  = 5;
	localparam int CTL_KEY_APPROVED   = 4;
	localparam int CTL_ENCRYPT_OFF    = 3;
	localparam int CTL_ENCRYPT_ON     = 2;
	localparam int CTL_AUTH_OFF       = 1;
	localparam int CTL_AUTH_START     = 0;

	// status bit positions
	localparam int STS_LINK_ERROR     = 7;
	localparam int STS_RECEIVER_IRQ   = 6;
	localparam int STS_DOWNSTREAM_LCK = 5;
	localparam int STS_KEY_READY      = 1;

	// synchroniser depth for pin inputs
	localparam int CPC_SYNC_DEPTH = 3;

	// ********************************************************
	// types
	// ********************************************************
	typedef enum logic [1:0] {
		ENC_WHEN_AUTH = 2'h0,
		ENC_REGISTER  = 2'h1,
		ENC_ALWAYS    = 2'h2,
		ENC_INBAND    = 2'h3
	} cpc_enc_mode_e;

	typedef enum logic [1:0] {
		VID_PLAIN,
		VID_ENCRYPTED,
		VID_BLUE
	} cpc_video_e;

	// events and levels from the cipher engine
	typedef struct packed {
		logic authenticated;  // authentication currently held
		logic key_read;       // pulse: receiver key loaded
		logic auth_fail;      // pulse: authentication failed
		logic auth_done;      // pulse: authentication completed
	} cpc_engine_s;

	// commands to the cipher engine
	typedef struct packed {
		logic auth_enable;    // level: authentication enabled
		logic auth_restart;   // pulse: start or restart
		logic protect_reset;  // pulse: reset transmitter
		logic key_approved;   // level: receiver key approved
		logic list_approved;  // level: repeater list approved
	} cpc_command_s;

endpackage : cpc_pkg

/* File: rtl/cpc_regs.sv */
`timescale 1ns/1ps
module cpc_regs
	import cpc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic          clk_i,                // 50 MHz clock
	input  wire logic          reset_n_i,            // async reset, low
	input  wire logic [ADDR_W-1:0] reg_addr_i,       // register address
	input  wire logic [7:0]    reg_wdata_i,          // write data
	input  wire logic          reg_wr_i,             // write strobe
	input  wire logic          reg_rd_i,             // read strobe
	output logic      [7:0]    reg_rdata_o,          // read data
	input  wire logic [1:0]    enc_mode_i,           // encryption policy
	input  wire logic          inband_encrypt_i,     // per-frame request
	input  wire cpc_engine_s   engine_i,             // engine status
	input  wire logic          link_error_i,         // channel error pulse
	input  wire logic          receiver_irq_input_n_i, // pin, active low
	input  wire logic          downstream_lock_i,    // pin, lock level
	output cpc_command_s       command_o,            // engine commands
	output cpc_video_e         video_sel_o,          // video treatment
	output logic               receiver_key_ready_o  // key ready flag
);

	// ********************************************************
	// elaboration checks
	// ********************************************************
	// byte-wide map; a wider address would only match with its upper bits zero
	if (ADDR_W != 8) begin : g_bad_addr
		$error("cpc_regs: ADDR_W must be 8");
	end

	// ********************************************************
	// helpers
	// ********************************************************
	// address match, shared by read and write decode
	function automatic logic hit(input logic [ADDR_W-1:0] a,
			input logic [7:0] target);
		hit = (a == target);
	endfunction : hit

	// ********************************************************
	// pin synchronisers
	// ********************************************************
	logic [CPC_SYNC_DEPTH-1:0] irq_sync;
	logic [CPC_SYNC_DEPTH-1:0] lock_sync;
	logic                      irq_level;
	logic                      lock_level;
	logic [CPC_SYNC_DEPTH-1:0] next_irq_sync;
	logic [CPC_SYNC_DEPTH-1:0] next_lock_sync;
	logic                      next_irq_level;
	logic                      next_lock_level;

	// levels change only once stages two and three agree
	// a one-cycle glitch on a pin never reaches the status view
	always_comb begin
		next_irq_sync  = {irq_sync[CPC_SYNC_DEPTH-2:0],
			receiver_irq_input_n_i};
		next_lock_sync = {lock_sync[CPC_SYNC_DEPTH-2:0],
			downstream_lock_i};
		next_irq_level  = irq_level;
		next_lock_level = lock_level;
		if (irq_sync[2] == irq_sync[1]) begin
			next_irq_level = irq_sync[2];
		end
		if (lock_sync[2] == lock_sync[1]) begin
			next_lock_level = lock_sync[2];
		end
	end

	// reset to zero so status reads 0x00 until pins settle
	// status levels start low; the active-low interrupt level so reads as asserted
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_sync   <= '0;
			lock_sync  <= '0;
			irq_level  <= 1'b0;
			lock_level <= 1'b0;
		end else begin
			irq_sync   <= next_irq_sync;
			lock_sync  <= next_lock_sync;
			irq_level  <= next_irq_level;
			lock_level <= next_lock_level;
		end
	end

	// ********************************************************
	// control and status state
	// ********************************************************
	logic       wr_ctrl;
	logic       rd_ctrl;
	logic       rd_status;
	logic       always_mode;
	logic       encrypt_on;
	logic       auth_en;
	logic       key_ok;
	logic       list_ok;
	logic       key_ready;
	logic       link_err;
	logic       restart_p;
	logic       reset_p;
	logic       next_encrypt_on;
	logic       next_auth_en;
	logic       next_key_ok;
	logic       next_list_ok;
	logic       next_key_ready;
	logic       next_link_err;
	logic       next_restart_p;
	logic       next_reset_p;
	logic [7:0] ctrl_view;
	logic [7:0] status_view;

	// a read and a write in one cycle both act
	assign wr_ctrl     = reg_wr_i && hit(reg_addr_i, CPC_CTRL_ADDR);
	assign rd_ctrl     = reg_rd_i && hit(reg_addr_i, CPC_CTRL_ADDR);
	// a status read is what clears the sticky error
	assign rd_status   = reg_rd_i && hit(reg_addr_i, CPC_STATUS_ADDR);
	// policy is a level from the configuration side
	assign always_mode = (cpc_enc_mode_e'(enc_mode_i) == ENC_ALWAYS);

	// next state of every control field
	always_comb begin
		next_encrypt_on = encrypt_on;
		next_auth_en    = auth_en;
		next_key_ok     = key_ok;
		next_list_ok    = list_ok;
		next_key_ready  = key_ready;
		next_link_err   = link_err;
		// strobes last one cycle, levels hold
		next_restart_p  = 1'b0;
		next_reset_p    = 1'b0;
		if (engine_i.auth_done) begin
			next_list_ok = 1'b0;
		end
		// key approval ends when ready rises
		if (engine_i.key_read) begin
			next_key_ok = 1'b0;
		end
		// ready drops on approval or failure
		if (key_ok || engine_i.auth_fail) begin
			next_key_ready = 1'b0;
		end
		// fresh key wins over a clear
		if (engine_i.key_read) begin
			next_key_ready = 1'b1;
		end
		if (rd_status) begin
			next_link_err = 1'b0;
		end
		// a new error beats the read
		if (link_error_i) begin
			next_link_err = 1'b1;
		end
		if (wr_ctrl) begin
			if (reg_wdata_i[CTL_LIST_APPROVED]) begin
				next_list_ok = 1'b1;
			end
			if (reg_wdata_i[CTL_KEY_APPROVED]) begin
				next_key_ok = 1'b1;
			end
			if (!always_mode) begin
				next_encrypt_on = reg_wdata_i[CTL_ENCRYPT_ON];
			end
			if (reg_wdata_i[CTL_ENCRYPT_OFF] && !always_mode) begin
				next_encrypt_on = 1'b0;
			end
			if (reg_wdata_i[CTL_AUTH_START]) begin
				next_auth_en   = 1'b1;
				next_restart_p = 1'b1;
			end
			if (reg_wdata_i[CTL_AUTH_OFF]) begin
				next_auth_en   = 1'b0;
				next_restart_p = 1'b0;
			end
			if (reg_wdata_i[CTL_PROTECT_RESET]) begin
				next_auth_en   = 1'b0;
				next_restart_p = 1'b0;
				next_reset_p   = 1'b1;
				next_key_ok    = 1'b0;
				next_list_ok   = 1'b0;
			end
		end
	end

	// control state registers
	// every flag inactive after reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			encrypt_on <= 1'b0;
			auth_en    <= 1'b0;
			key_ok     <= 1'b0;
			list_ok    <= 1'b0;
			key_ready  <= 1'b0;
			link_err   <= 1'b0;
			restart_p  <= 1'b0;
			reset_p    <= 1'b0;
		end else begin
			encrypt_on <= next_encrypt_on;
			auth_en    <= next_auth_en;
			key_ok     <= next_key_ok;
			list_ok    <= next_list_ok;
			key_ready  <= next_key_ready;
			link_err   <= next_link_err;
			restart_p  <= next_restart_p;
			reset_p    <= next_reset_p;
		end
	end

	// ********************************************************
	// read views
	// ********************************************************
	// self-clearing and reserved bits always read zero
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[CTL_LIST_APPROVED] = list_ok;
		ctrl_view[CTL_KEY_APPROVED]  = key_ok;
		ctrl_view[CTL_ENCRYPT_ON]    = encrypt_on || always_mode;
		// live enable state, not last write
		ctrl_view[CTL_AUTH_START]    = auth_en;
		ctrl_view[CTL_RESERVED]      = 1'b0;
	end

	always_comb begin
		status_view = CPC_STATUS_RST;
		status_view[STS_LINK_ERROR]     = link_err;
		// low after reset; an idle high pin shows four edges later
		// raw active-low interrupt level
		status_view[STS_RECEIVER_IRQ]   = irq_level;
		status_view[STS_DOWNSTREAM_LCK] = lock_level;
		status_view[STS_KEY_READY]      = key_ready;
	end

	// ********************************************************
	// outputs
	// ********************************************************
	cpc_video_e   next_video;
	cpc_command_s next_command;
	logic [7:0]   next_rdata;
	logic         enc_active;

	// video treatment picked by the policy field
	always_comb begin
		case (cpc_enc_mode_e'(enc_mode_i))
			ENC_WHEN_AUTH: enc_active = engine_i.authenticated;
			ENC_REGISTER:  enc_active = encrypt_on;
			ENC_ALWAYS:    enc_active = 1'b1;
			ENC_INBAND:    enc_active = inband_encrypt_i;
			default:       enc_active = 1'b0;
		endcase
		next_video = VID_PLAIN;
		// blue keeps protected video off an unauthenticated link
		// encrypted when authenticated, else blue
		if (enc_active) begin
			next_video = engine_i.authenticated ? VID_ENCRYPTED : VID_BLUE;
		end
		// commands mirror next state so they align with the flags
		next_command.auth_enable   = next_auth_en;
		next_command.auth_restart  = next_restart_p;
		next_command.protect_reset = next_reset_p;
		next_command.key_approved  = next_key_ok;
		next_command.list_approved = next_list_ok;
		// read data holds until the next read strobe
		next_rdata = reg_rdata_o;
		if (rd_ctrl) begin
			next_rdata = ctrl_view;
		end else if (rd_status) begin
			next_rdata = status_view;
		// any other address reads as zero
		end else if (reg_rd_i) begin
			next_rdata = 8'h00;
		end
	end

	// every output straight from a flip-flop
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			video_sel_o          <= VID_PLAIN;
			command_o            <= '0;
			reg_rdata_o          <= CPC_RDATA_RST;
			receiver_key_ready_o <= 1'b0;
		end else begin
			video_sel_o          <= next_video;
			command_o            <= next_command;
			reg_rdata_o          <= next_rdata;
			receiver_key_ready_o <= next_key_ready;
		end
	end

endmodule : cpc_regs

/* File: verif/content_protect_ctrl_status_tb.sv */
`timescale 1ns/1ps
module content_protect_ctrl_status_tb;
	import cpc_pkg::*;
	logic clk_i, reset_n_i, reg_wr_i, reg_rd_i, inband_i;
	logic [7:0] reg_addr_i, reg_wdata_i, rdata, rd_data;
	logic [1:0] enc_mode_i;
	logic err_req, irq_lvl, lock_lvl, err_pin, irq_n, lock_pin, key_rdy;
	logic [31:0] r;
	cpc_engine_s eng;
	cpc_command_s cmd;
	cpc_video_e vid;
	int num_errors, checked, i, m_auth;
	logic [7:0] wv[7] = '{8'h01, 8'h00, 8'h40, 8'h02, 8'h01, 8'h81, 8'h03};
	cpc_regs DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
		.enc_mode_i(enc_mode_i), .inband_encrypt_i(inband_i),
		.engine_i(eng), .link_error_i(err_pin),
		.receiver_irq_input_n_i(irq_n), .downstream_lock_i(lock_pin),
		.command_o(cmd), .video_sel_o(vid), .receiver_key_ready_o(key_rdy));
	cpc_partner u_far (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_i(cmd),
		.err_i(err_req), .irq_i(irq_lvl), .lock_i(lock_lvl), .eng_o(eng),
		.err_o(err_pin), .irq_n_o(irq_n), .lock_o(lock_pin));
	// bus cycles: one strobe pulse each
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_i);
		rd_data = rdata;
	endtask : rd
	task automatic chk8(input string n, input logic [7:0] e, g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk8
	task automatic chkv(input cpc_video_e e);
		checked++;
		if (vid !== e) begin
			num_errors++;
			$display("[FAIL] video expected %0d seen %0d", e, vid);
		end
	endtask : chkv
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	// clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// watchdog, far beyond the expected run
	initial begin
		#400000;
		num_errors++;
		close_out();
	end
	// main sequence
	initial begin
		{reset_n_i, reg_wr_i, reg_rd_i, inband_i, err_req} = '0;
		{irq_lvl, lock_lvl, reg_addr_i, reg_wdata_i} = '0;
		enc_mode_i = 2'h1;
		m_auth = 0;
		void'($urandom(45476));
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(CPC_STATUS_ADDR);
		chk8("status", CPC_STATUS_RST, rd_data);
		$display("reset test done");
		for (i = 0; i < 7; i++) begin
			wr(CPC_CTRL_ADDR, wv[i]);
			m_auth = (wv[i][7] || wv[i][1]) ? 0 : (wv[i][0] ? 1 : m_auth);
			rd(CPC_CTRL_ADDR);
			chk8("auth", {7'h0, m_auth[0]}, rd_data & 8'h41);
		end
		$display("auth test done");
		wr(CPC_CTRL_ADDR, 8'h10);
		rd(CPC_STATUS_ADDR);
		chk8("key_clear", 8'h00, rd_data & 8'h02);
		wr(CPC_CTRL_ADDR, 8'h01);
		for (i = 0; i < 50 && !eng.key_read; i++) @(posedge clk_i);
		rd(CPC_STATUS_ADDR);
		chk8("key_ready", 8'h02, rd_data & 8'h02);
		wr(CPC_CTRL_ADDR, 8'h10);
		rd(CPC_STATUS_ADDR);
		chk8("key_ready", 8'h00, rd_data & 8'h02);
		wr(CPC_CTRL_ADDR, 8'h24);
		for (i = 0; i < 50 && !eng.authenticated; i++) @(posedge clk_i);
		rd(CPC_CTRL_ADDR);
		chk8("list", 8'h15, rd_data & 8'h35);
		chkv(VID_ENCRYPTED);
		wr(CPC_CTRL_ADDR, 8'h08);
		repeat (2) @(posedge clk_i);
		chkv(VID_PLAIN);
		wr(CPC_CTRL_ADDR, 8'h06);
		repeat (4) @(posedge clk_i);
		chkv(VID_BLUE);
		for (i = 0; i < 4; i++) begin
			enc_mode_i <= 2'(i);
			inband_i <= (i == 3);
			wr(CPC_CTRL_ADDR, 8'h08);
			rd(CPC_CTRL_ADDR);
			chk8("always", (i == 2) ? 8'h04 : 8'h00, rd_data & 8'h04);
			chkv((i >= 2) ? VID_BLUE : VID_PLAIN);
		end
		$display("key and video test done");
		for (i = 0; i < 8; i++) begin
			r = $urandom;
			irq_lvl <= r[0];
			lock_lvl <= r[1];
			err_req <= r[2];
			@(posedge clk_i);
			err_req <= 1'b0;
			repeat (6) @(posedge clk_i);
			rd(CPC_STATUS_ADDR);
			chk8("pins", {r[2], r[0], r[1], 5'h0}, rd_data & 8'hE0);
			rd(CPC_STATUS_ADDR);
			chk8("err_clr", {1'b0, r[0], r[1], 5'h0}, rd_data & 8'hE0);
		end
		$display("status test done");
		close_out();
	end
endmodule : content_protect_ctrl_status_tb

/* File: verif/cpc_partner.sv */
`timescale 1ns/1ps
module cpc_partner
	import cpc_pkg::*;
(
	input wire logic         clk_i,     // clock
	input wire logic         reset_n_i, // reset, low
	input wire cpc_command_s cmd_i,     // device commands
	input wire logic         err_i,     // inject channel error
	input wire logic         irq_i,     // interrupt pin level
	input wire logic         lock_i,    // lock level
	output cpc_engine_s      eng_o,     // engine status
	output logic             err_o,     // error pulse
	output logic             irq_n_o,   // interrupt pin
	output logic             lock_o     // lock pin
);
	int nk;
	int na;
	// engine: key after restart, completion after both approvals
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			eng_o <= '0;
			err_o <= 1'b0;
			irq_n_o <= 1'b0;
			lock_o <= 1'b0;
			nk = 0;
			na = 0;
		end else begin
			eng_o.key_read <= 1'b0;
			eng_o.auth_done <= 1'b0;
			if (cmd_i.auth_restart) begin
				nk = 4;
			end else if (nk > 0) begin
				nk--;
				eng_o.key_read <= (nk == 0);
			end
			if (cmd_i.key_approved && cmd_i.list_approved && na == 0
				&& !eng_o.authenticated) begin
				na = 3;
			end else if (na > 0) begin
				na--;
				eng_o.auth_done <= (na == 0);
				eng_o.authenticated <= (na == 0);
			end
			if (cmd_i.protect_reset || !cmd_i.auth_enable) begin
				eng_o.authenticated <= 1'b0;
			end
			err_o <= err_i;
			irq_n_o <= irq_i;
			lock_o <= lock_i;
		end
	end
endmodule : cpc_partner

/* File: verif/cpc_regs_monitor.sv */
`timescale 1ns/1ps
module cpc_regs_monitor
	import cpc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic              clk_i,       // clock
	input wire logic              reset_n_i,   // reset, low
	input wire logic [ADDR_W-1:0] reg_addr_i,  // address
	input wire logic [7:0]        reg_wdata_i, // write data
	input wire logic              reg_wr_i,    // write strobe
	input wire logic              reg_rd_i,    // read strobe
	input wire logic [7:0]        reg_rdata_o, // read data
	input wire logic [1:0]        enc_mode_i,  // policy
	input wire cpc_engine_s       engine_i,    // engine status
	input wire cpc_command_s      command_o,   // commands
	input wire cpc_video_e        video_sel_o, // video kind
	input wire logic              receiver_key_ready_o // key flag
);
	logic wc;
	logic rc;
	// control strobes; a read beside a write is left out on purpose
	assign wc = reg_wr_i && (reg_addr_i == CPC_CTRL_ADDR);
	assign rc = reg_rd_i && (reg_addr_i == CPC_CTRL_ADDR) && !reg_wr_i;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	auth_restart_a: assert property (
		wc && reg_wdata_i[0] && !reg_wdata_i[1] && !reg_wdata_i[7]
		|=> command_o.auth_restart && command_o.auth_enable
		##1 !command_o.auth_restart) else $error("restart wrong");
	auth_off_a: assert property (
		wc && reg_wdata_i[1] |=> !command_o.auth_enable)
		else $error("disable wrong");
	protect_reset_a: assert property (
		wc && reg_wdata_i[7] |=> command_o.protect_reset
		&& !command_o.auth_enable ##1 !command_o.protect_reset)
		else $error("reset pulse wrong");
	zero_write_a: assert property (
		wc && ((reg_wdata_i & 8'h83) == 8'h00)
		|=> $stable(command_o.auth_enable))
		else $error("zero write acted");
	ctrl_read_a: assert property (
		rc |=> reg_rdata_o[0] == $past(command_o.auth_enable)
		&& !reg_rdata_o[6]) else $error("control read wrong");
	enc_always_a: assert property (
		rc && enc_mode_i == 2'h2 |=> reg_rdata_o[2])
		else $error("always mode read wrong");
	plain_video_a: assert property (
		wc && reg_wdata_i[3] && enc_mode_i == 2'h1
		|-> ##2 video_sel_o == VID_PLAIN) else $error("not plain");
	key_ready_a: assert property (
		engine_i.key_read |=> receiver_key_ready_o)
		else $error("key ready missing");
	// main scenarios reached
	cover property (wc && reg_wdata_i[0]);
	cover property (engine_i.auth_done);
	cover property (video_sel_o == VID_ENCRYPTED);
endmodule : cpc_regs_monitor

bind cpc_regs cpc_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .enc_mode_i(enc_mode_i),
	.engine_i(engine_i), .command_o(command_o),
	.video_sel_o(video_sel_o),
	.receiver_key_ready_o(receiver_key_ready_o)
);
